// *** hdl/gauge_pkg.sv ***
`default_nettype none
package gauge_pkg;

  // ---------------------------------------------------------------
  // Register map (printed offsets, byte-wide address)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS       = 8'h00;
  localparam logic [7:0] ADDR_CUR_LIMITS   = 8'h01;
  localparam logic [7:0] ADDR_VOLT_LIMITS  = 8'h02;
  localparam logic [7:0] ADDR_TEMP_LIMITS  = 8'h03;
  localparam logic [7:0] ADDR_SOC_LIMITS   = 8'h04;
  localparam logic [7:0] ADDR_REM_CAP      = 8'h05;
  localparam logic [7:0] ADDR_SOC          = 8'h06;
  localparam logic [7:0] ADDR_FULL_CAP     = 8'h10;
  localparam logic [7:0] ADDR_TTE          = 8'h11;
  localparam logic [7:0] ADDR_CYCLES       = 8'h17;
  localparam logic [7:0] ADDR_CONFIG       = 8'h1D;
  localparam logic [7:0] ADDR_TTF          = 8'h20;

  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam int ST_POR  = 1;
  localparam int ST_IMN  = 2;
  localparam int ST_BST  = 3;
  localparam int ST_IMX  = 6;
  localparam int ST_STEP = 7;
  localparam int ST_VMN  = 8;
  localparam int ST_TMN  = 9;
  localparam int ST_SMN  = 10;
  localparam int ST_INS  = 11;
  localparam int ST_VMX  = 12;
  localparam int ST_TMX  = 13;
  localparam int ST_SMX  = 14;
  localparam int ST_REM  = 15;

  // Config bits: sticky per channel (current, voltage, temp, charge)
  localparam int CFG_STICKY_LSB = 0;
  localparam int CFG_ALERT_EN   = 4;
  localparam int CFG_DONE       = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] STATUS_RST     = 16'h0002;
  localparam logic [15:0] CUR_LIM_RST    = 16'h7F80;
  localparam logic [15:0] VOLT_LIM_RST   = 16'hFF00;
  localparam logic [15:0] TEMP_LIM_RST   = 16'h7F80;
  localparam logic [15:0] SOC_LIM_RST    = 16'hFF00;
  localparam logic [5:0]  CONFIG_RST     = 6'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 10_000_000;
  localparam int VALID_DELAY_MS = 351;
  localparam int VALID_CYCLES   = (CLK_HZ / 1000) * VALID_DELAY_MS;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] voltage;
    logic [15:0] temp;
  } meas_t;

  typedef struct packed {
    logic [15:0] rem_cap;
    logic [15:0] soc;
    logic [15:0] full_cap;
    logic [15:0] time_until_empty;
    logic [15:0] cycles;
    logic [15:0] time_until_full;
  } results_t;

endpackage
`default_nettype wire

// *** hdl/gauge_status_and_result_regs.sv ***
// Operation
// [R1] Results read zero until 351ms after configuration
// [R2] Time, resistance, voltage words keep standard steps
// [R3] Charge percent unsigned, 1/256 percent per bit
// [R4] Current signed, 1.5625uV per sense unit
// [R5] Temperature signed, 1/256 degree per bit
// [R6] Capacity unsigned, 5.0uVH per sense unit
// [R7] Cycle count one percent per bit
// [R8] Power-on flag set by reset, host clears
// [R9] Status resets to 0x0002
// [R10] Current below/above limits sets D2/D6
// [R11] Voltage below/above limits sets D8/D12
// [R12] Temperature below/above limits sets D9/D13
// [R13] Charge below/above limits sets D10/D14
// [R14] Absent bit D3 follows cell presence
// [R15] Whole-percent charge crossing sets D7, sticky
// [R16] Cell insertion sets D11 until cleared
// [R17] Cell removal sets D15 until cleared
// [R18] D0, D4, D5 undefined; host ignores
// [R19] Sticky setting chooses host or auto clear
// [R20] Alert enable gates only the pin
// [R21] Host clears flag by writing zero
`default_nettype none
module gauge_status_and_result_regs #(
  parameter int VALID_CYCLES = gauge_pkg::VALID_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Register port
  input  wire logic [7:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [15:0]            rdata,
  // Measurement side
  input  wire gauge_pkg::meas_t    meas,
  input  wire logic                meas_valid,
  input  wire gauge_pkg::results_t results,
  input  wire logic                results_valid,
  // Detect input pin, high while no cell pulls it down
  input  wire logic              detect_input_pin,
  // Open-drain alert pin, active low
  output logic                   alert_output_pin_o,
  output logic                   alert_output_pin_oe,
  // Results valid indication
  output logic                   results_ready
);

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [15:0] cur_lim_q, volt_lim_q, temp_lim_q, soc_lim_q;
  logic [5:0]  cfg_q;
  logic        wr_status, wr_cfg;
  assign wr_status = wr && (addr == gauge_pkg::ADDR_STATUS);
  assign wr_cfg    = wr && (addr == gauge_pkg::ADDR_CONFIG);
  always_ff @(posedge clk) begin
    if (srst) begin
      cur_lim_q  <= gauge_pkg::CUR_LIM_RST;
      volt_lim_q <= gauge_pkg::VOLT_LIM_RST;
      temp_lim_q <= gauge_pkg::TEMP_LIM_RST;
      soc_lim_q  <= gauge_pkg::SOC_LIM_RST;
      cfg_q      <= gauge_pkg::CONFIG_RST;
    end else if (wr) begin
      if (addr == gauge_pkg::ADDR_CUR_LIMITS) cur_lim_q <= wdata;
      if (addr == gauge_pkg::ADDR_VOLT_LIMITS) volt_lim_q <= wdata;
      if (addr == gauge_pkg::ADDR_TEMP_LIMITS) temp_lim_q <= wdata;
      if (addr == gauge_pkg::ADDR_SOC_LIMITS) soc_lim_q <= wdata;
      if (wr_cfg) cfg_q <= wdata[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Detect pin synchroniser and edges
  // ---------------------------------------------------------------
  logic det_s1_q, det_s2_q, det_s3_q, det_armed_q;
  logic [1:0] det_fill_q;
  logic inserted, removed;
  always_ff @(posedge clk) begin
    if (srst) begin
      det_s1_q    <= 1'b0;
      det_s2_q    <= 1'b0;
      det_s3_q    <= 1'b0;
      det_armed_q <= 1'b0;
      det_fill_q  <= 2'b00;
    end else begin
      det_s1_q    <= detect_input_pin;
      det_s2_q    <= det_s1_q;
      det_s3_q    <= det_s2_q;
      det_fill_q  <= {det_fill_q[0], 1'b1};
      det_armed_q <= det_fill_q[1];
    end
  end
  // Edges are ignored until the pipeline holds real pin samples
  assign inserted = det_armed_q && det_s3_q && !det_s2_q;  // R16
  assign removed  = det_armed_q && !det_s3_q && det_s2_q;  // R17

  // ---------------------------------------------------------------
  // Result holding and valid timer
  // ---------------------------------------------------------------
  gauge_pkg::results_t res_q;
  logic [21:0] vtimer_q;
  logic        cfg_done_d1_q, valid_q;
  logic        step_hit;
  always_ff @(posedge clk) begin
    if (srst) begin
      res_q <= '0;
    end else if (results_valid) begin
      res_q <= results;  // R2 R3 R6 R7
    end
  end
  // A whole-percent crossing shows up as a new upper byte
  assign step_hit = results_valid && (results.soc[15:8] != res_q.soc[15:8]);  // R15
  always_ff @(posedge clk) begin
    if (srst) begin
      vtimer_q      <= '0;
      cfg_done_d1_q <= 1'b0;
      valid_q       <= 1'b0;
    end else begin
      cfg_done_d1_q <= cfg_q[gauge_pkg::CFG_DONE];
      if (cfg_q[gauge_pkg::CFG_DONE] && !cfg_done_d1_q) begin
        vtimer_q <= '0;
        valid_q  <= 1'b0;
      end else if (!cfg_q[gauge_pkg::CFG_DONE]) begin
        valid_q  <= 1'b0;
      end else if (!valid_q) begin
        if (vtimer_q == 22'(VALID_CYCLES - 1)) begin
          valid_q <= 1'b1;  // R1
        end
        vtimer_q <= vtimer_q + 22'h000001;
      end
    end
  end
  assign results_ready = valid_q;

  // ---------------------------------------------------------------
  // Limit compare: upper byte of each reading against min/max bytes
  // ---------------------------------------------------------------
  // Channel order: 0 current, 1 voltage, 2 temperature, 3 charge
  logic [3:0] lo_hit, hi_hit, upd, sticky;
  logic [3:0] lo_q, hi_q;
  always_comb begin
    lo_hit[0] = $signed(meas.current[15:8]) < $signed(cur_lim_q[7:0]);   // R10 R4
    hi_hit[0] = $signed(meas.current[15:8]) > $signed(cur_lim_q[15:8]);  // R10 R4
    lo_hit[1] = meas.voltage[15:8] < volt_lim_q[7:0];                    // R11
    hi_hit[1] = meas.voltage[15:8] > volt_lim_q[15:8];                   // R11
    lo_hit[2] = $signed(meas.temp[15:8]) < $signed(temp_lim_q[7:0]);     // R12 R5
    hi_hit[2] = $signed(meas.temp[15:8]) > $signed(temp_lim_q[15:8]);    // R12 R5
    lo_hit[3] = results.soc[15:8] < soc_lim_q[7:0];                      // R13
    hi_hit[3] = results.soc[15:8] > soc_lim_q[15:8];                     // R13
    upd       = {results_valid, meas_valid, meas_valid, meas_valid};
  end
  assign sticky = cfg_q[gauge_pkg::CFG_STICKY_LSB +: 4];
  localparam int LO_POS [4] = '{gauge_pkg::ST_IMN, gauge_pkg::ST_VMN,
                                gauge_pkg::ST_TMN, gauge_pkg::ST_SMN};
  localparam int HI_POS [4] = '{gauge_pkg::ST_IMX, gauge_pkg::ST_VMX,
                                gauge_pkg::ST_TMX, gauge_pkg::ST_SMX};
  // Limit flags set regardless of the alert enable; set wins over clear
  for (genvar c = 0; c < 4; c++) begin : g_lim
    always_ff @(posedge clk) begin
      if (srst) begin
        lo_q[c] <= 1'b0;
        hi_q[c] <= 1'b0;
      end else begin
        if (upd[c] && lo_hit[c]) begin
          lo_q[c] <= 1'b1;  // R20
        end else if (wr_status && !wdata[LO_POS[c]]) begin
          lo_q[c] <= 1'b0;  // R21
        end else if (upd[c] && !sticky[c]) begin
          lo_q[c] <= 1'b0;  // R19
        end
        if (upd[c] && hi_hit[c]) begin
          hi_q[c] <= 1'b1;  // R20
        end else if (wr_status && !wdata[HI_POS[c]]) begin
          hi_q[c] <= 1'b0;  // R21
        end else if (upd[c] && !sticky[c]) begin
          hi_q[c] <= 1'b0;  // R19
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  logic por_q, step_q, ins_q, rem_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      por_q  <= 1'b1;  // R8 R9
      step_q <= 1'b0;
      ins_q  <= 1'b0;
      rem_q  <= 1'b0;
    end else begin
      if (wr_status && !wdata[gauge_pkg::ST_POR]) por_q <= 1'b0;  // R8
      if (step_hit) begin
        step_q <= 1'b1;  // R15
      end else if (wr_status && !wdata[gauge_pkg::ST_STEP]) begin
        step_q <= 1'b0;
      end
      if (inserted) begin
        ins_q <= 1'b1;  // R16
      end else if (wr_status && !wdata[gauge_pkg::ST_INS]) begin
        ins_q <= 1'b0;
      end
      if (removed) begin
        rem_q <= 1'b1;  // R17
      end else if (wr_status && !wdata[gauge_pkg::ST_REM]) begin
        rem_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  logic [15:0] status;
  logic        absent;
  // Absent follows the pin after sync; reads 0 until samples arrive
  assign absent = det_armed_q && det_s3_q;  // R14
  always_comb begin
    status                       = 16'h0000;  // R18
    status[gauge_pkg::ST_POR]    = por_q;
    status[gauge_pkg::ST_BST]    = absent;
    status[gauge_pkg::ST_STEP]   = step_q;
    status[gauge_pkg::ST_INS]    = ins_q;
    status[gauge_pkg::ST_REM]    = rem_q;
    for (int c = 0; c < 4; c++) begin
      status[LO_POS[c]] = lo_q[c];
      status[HI_POS[c]] = hi_q[c];
    end
  end

  // ---------------------------------------------------------------
  // Read port: data stands only in the cycle after the strobe
  // ---------------------------------------------------------------
  logic [15:0] rdata_d, rdata_q, res_view;
  always_comb begin
    res_view = 16'h0000;
    rdata_d  = 16'h0000;
    unique case (addr)
      gauge_pkg::ADDR_REM_CAP:  res_view = res_q.rem_cap;
      gauge_pkg::ADDR_SOC:      res_view = res_q.soc;
      gauge_pkg::ADDR_FULL_CAP: res_view = res_q.full_cap;
      gauge_pkg::ADDR_TTE:      res_view = res_q.time_until_empty;
      gauge_pkg::ADDR_CYCLES:   res_view = res_q.cycles;
      gauge_pkg::ADDR_TTF:      res_view = res_q.time_until_full;
      default:                  res_view = 16'h0000;
    endcase
    unique case (addr)
      gauge_pkg::ADDR_STATUS:      rdata_d = status;
      gauge_pkg::ADDR_CUR_LIMITS:  rdata_d = cur_lim_q;
      gauge_pkg::ADDR_VOLT_LIMITS: rdata_d = volt_lim_q;
      gauge_pkg::ADDR_TEMP_LIMITS: rdata_d = temp_lim_q;
      gauge_pkg::ADDR_SOC_LIMITS:  rdata_d = soc_lim_q;
      gauge_pkg::ADDR_CONFIG:      rdata_d = {10'h000, cfg_q};
      default:                     rdata_d = valid_q ? res_view : 16'h0000;  // R1
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd ? rdata_d : 16'h0000;
    end
  end
  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // Alert pin: only the pin is gated by the enable
  // ---------------------------------------------------------------
  logic alert_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= cfg_q[gauge_pkg::CFG_ALERT_EN] && (|{lo_q, hi_q});  // R20
    end
  end
  assign alert_output_pin_o  = 1'b0;
  assign alert_output_pin_oe = alert_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_status_reset;
    @(posedge clk) $fell(srst) |-> (status == gauge_pkg::STATUS_RST);
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status not 0x0002 after reset"); // R9
  property p_por_hold;
    @(posedge clk) disable iff (srst)
      por_q && !(wr_status && !wdata[gauge_pkg::ST_POR]) |=> por_q;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on flag dropped without write"); // R8
  property p_cur_low;
    @(posedge clk) disable iff (srst)
      meas_valid && lo_hit[0] |=> status[gauge_pkg::ST_IMN];
  endproperty
  a_cur_low: assert property (p_cur_low) else $error("low current flag not set"); // R10
  property p_volt_high;
    @(posedge clk) disable iff (srst)
      meas_valid && hi_hit[1] |=> status[gauge_pkg::ST_VMX];
  endproperty
  a_volt_high: assert property (p_volt_high) else $error("high voltage flag not set"); // R11
  property p_temp_low;
    @(posedge clk) disable iff (srst)
      meas_valid && lo_hit[2] |=> status[gauge_pkg::ST_TMN];
  endproperty
  a_temp_low: assert property (p_temp_low) else $error("low temperature flag not set"); // R12
  property p_soc_high;
    @(posedge clk) disable iff (srst)
      results_valid && hi_hit[3] |=> status[gauge_pkg::ST_SMX];
  endproperty
  a_soc_high: assert property (p_soc_high) else $error("high charge flag not set"); // R13
  property p_sticky_auto;
    @(posedge clk) disable iff (srst)
      meas_valid && !sticky[0] && !lo_hit[0] |=> !status[gauge_pkg::ST_IMN];
  endproperty
  a_sticky_auto: assert property (p_sticky_auto) else $error("non-sticky flag not cleared"); // R19
  property p_absent;
    @(posedge clk) disable iff (srst)
      det_armed_q |-> (status[gauge_pkg::ST_BST] == $past(detect_input_pin, 3));
  endproperty
  a_absent: assert property (p_absent) else $error("absent bit wrong"); // R14
  property p_insert;
    @(posedge clk) disable iff (srst)
      det_armed_q && $fell(det_s2_q) |=> status[gauge_pkg::ST_INS];
  endproperty
  a_insert: assert property (p_insert) else $error("insertion flag missing"); // R16
  property p_remove;
    @(posedge clk) disable iff (srst)
      removed |=> rem_q;
  endproperty
  a_remove: assert property (p_remove) else $error("removal flag missing"); // R17
  property p_step;
    @(posedge clk) disable iff (srst)
      step_hit |=> step_q;
  endproperty
  a_step: assert property (p_step) else $error("charge step flag missing"); // R15
  property p_hidden_results;
    @(posedge clk) disable iff (srst)
      rd && !valid_q && (addr == gauge_pkg::ADDR_SOC) |=> (rdata == 16'h0000);
  endproperty
  a_hidden_results: assert property (p_hidden_results) else $error("results shown early"); // R1
  property p_dontcare_zero;
    @(posedge clk) disable iff (srst)
      rd && (addr == gauge_pkg::ADDR_STATUS) |=> (rdata[0] == 1'b0) && (rdata[5:4] == 2'b00);
  endproperty
  a_dontcare_zero: assert property (p_dontcare_zero) else $error("reserved bits nonzero"); // R18
  c_por_cleared: cover property (@(posedge clk) disable iff (srst) $fell(por_q));
  c_results_valid: cover property (@(posedge clk) disable iff (srst) $rose(valid_q));
  c_alert_driven: cover property (@(posedge clk) disable iff (srst) $rose(alert_output_pin_oe));
  c_insert_remove: cover property (@(posedge clk) disable iff (srst) ins_q && rem_q);

endmodule
`default_nettype wire

// *** tb/host_bus_model.sv ***
`default_nettype none
module host_bus_model (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic [7:0]       addr,
  output logic [15:0]      wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  initial begin
    addr  = 8'h00;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    // Idle data bus flips so a stale value never looks valid
    wdata <= ~d;
  endtask

  // Data stand only in the cycle after the strobe, so it is taken at the next edge
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // Read-modify-write keeps the other flags that were set when status was read
  task automatic clear_flags(input logic [15:0] mask);
    logic [15:0] st;
    read_reg(gauge_pkg::ADDR_STATUS, st);
    write_reg(gauge_pkg::ADDR_STATUS, st & ~mask & 16'hFFCE);
  endtask
endmodule
`default_nettype wire

// *** tb/test_gauge_status_and_result_regs.sv ***
`default_nettype none
module test_gauge_status_and_result_regs;
  timeunit 1ns;
  timeprecision 1ns;

  // Short valid timer keeps the run brief
  localparam int VALID_N = 20;

  logic                clk;
  logic                srst;
  logic [7:0]          addr;
  logic [15:0]         wdata;
  logic                wr;
  logic                rd;
  logic [15:0]         rdata;
  gauge_pkg::meas_t    meas;
  logic                meas_valid;
  gauge_pkg::results_t results;
  logic                results_valid;
  logic                detect_pin;
  logic                alert_o;
  logic                alert_oe;
  logic                results_ready;
  int                  num_errors;
  int                  comparisons;
  logic [15:0]         st;
  logic [5:0]          cfg;

  always #50 clk = ~clk;

  host_bus_model host_u (
    .clk  (clk),
    .addr (addr),
    .wdata(wdata),
    .wr   (wr),
    .rd   (rd),
    .rdata(rdata)
  );

  gauge_status_and_result_regs #(.VALID_CYCLES(VALID_N)) dut_u (
    .clk                (clk),
    .srst               (srst),
    .addr               (addr),
    .wdata              (wdata),
    .wr                 (wr),
    .rd                 (rd),
    .rdata              (rdata),
    .meas               (meas),
    .meas_valid         (meas_valid),
    .results            (results),
    .results_valid      (results_valid),
    .detect_input_pin   (detect_pin),
    .alert_output_pin_o (alert_o),
    .alert_output_pin_oe(alert_oe),
    .results_ready      (results_ready)
  );

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic check_bit(input string n, input logic b, input logic e);
    check(n, {15'h0000, b}, {15'h0000, e});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic read_status();
    host_u.read_reg(gauge_pkg::ADDR_STATUS, st);
  endtask

  task automatic write_cfg();
    host_u.write_reg(gauge_pkg::ADDR_CONFIG, {10'h000, cfg});
  endtask

  // Channel 0..2 ride on meas_valid, channel 3 is the charge word
  task automatic drive_reading(input int ch, input logic [15:0] v);
    @(posedge clk);
    case (ch)
      0: meas.current <= v;
      1: meas.voltage <= v;
      2: meas.temp <= v;
      default: results.soc <= v;
    endcase
    if (ch < 3) begin
      meas_valid <= 1'b1;
    end else begin
      results_valid <= 1'b1;
    end
    @(posedge clk);
    meas_valid    <= 1'b0;
    results_valid <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic scen_reset();
    logic [15:0] d;
    read_status();
    check("status_reset", st & 16'hFFCE, gauge_pkg::STATUS_RST);
    check_bit("ready_reset", results_ready, 1'b0);
    host_u.read_reg(8'h3F, d);
    check("unmapped", d, 16'h0000);
    host_u.clear_flags(16'h0001 << gauge_pkg::ST_POR);
    read_status();
    check_bit("por_cleared", st[gauge_pkg::ST_POR], 1'b0);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    read_status();
    check_bit("por_again", st[gauge_pkg::ST_POR], 1'b1);
  endtask

  task automatic limit_case(input int ch, input logic [7:0] adr, input logic [15:0] lim,
                            input logic [15:0] lo_v, input logic [15:0] hi_v,
                            input logic [15:0] in_v, input int lo_b, input int hi_b);
    host_u.write_reg(adr, lim);
    cfg[ch] = 1'b1;
    write_cfg();
    drive_reading(ch, lo_v);
    read_status();
    check_bit("min_flag", st[lo_b], 1'b1);
    check_bit("max_flag", st[hi_b], 1'b0);
    check_bit("pin_gated", alert_oe, 1'b0);
    drive_reading(ch, in_v);
    read_status();
    check_bit("min_sticky", st[lo_b], 1'b1);
    host_u.clear_flags(16'h0001 << lo_b);
    read_status();
    check_bit("min_host_clear", st[lo_b], 1'b0);
    cfg[ch] = 1'b0;
    write_cfg();
    drive_reading(ch, hi_v);
    read_status();
    check_bit("max_flag_set", st[hi_b], 1'b1);
    drive_reading(ch, in_v);
    read_status();
    check_bit("max_auto_clear", st[hi_b], 1'b0);
  endtask

  task automatic scen_limits();
    // Signed channels use min -16, max 16; unsigned ones min 0x40, max 0x80
    limit_case(0, gauge_pkg::ADDR_CUR_LIMITS, 16'h10F0, 16'hE000, 16'h2000, 16'h0000,
               gauge_pkg::ST_IMN, gauge_pkg::ST_IMX);
    limit_case(1, gauge_pkg::ADDR_VOLT_LIMITS, 16'h8040, 16'h3000, 16'h9000, 16'h6000,
               gauge_pkg::ST_VMN, gauge_pkg::ST_VMX);
    limit_case(2, gauge_pkg::ADDR_TEMP_LIMITS, 16'h10F0, 16'hE000, 16'h1100, 16'hFF00,
               gauge_pkg::ST_TMN, gauge_pkg::ST_TMX);
    limit_case(3, gauge_pkg::ADDR_SOC_LIMITS, 16'h8040, 16'h3000, 16'h9000, 16'h6000,
               gauge_pkg::ST_SMN, gauge_pkg::ST_SMX);
  endtask

  task automatic scen_alert();
    cfg[0] = 1'b1;
    cfg[4] = 1'b1;
    write_cfg();
    drive_reading(0, 16'hE000);
    read_status();
    check_bit("pin_active", alert_oe, 1'b1);
    check_bit("pin_level", alert_o, 1'b0);
    host_u.clear_flags(16'h0001 << gauge_pkg::ST_IMN);
    repeat (2) @(posedge clk);
    check_bit("pin_released", alert_oe, 1'b0);
  endtask

  task automatic scen_step();
    drive_reading(3, 16'h6000);
    host_u.clear_flags(16'h0001 << gauge_pkg::ST_STEP);
    drive_reading(3, 16'h6080);
    read_status();
    check_bit("step_within", st[gauge_pkg::ST_STEP], 1'b0);
    drive_reading(3, 16'h6100);
    read_status();
    check_bit("step_cross", st[gauge_pkg::ST_STEP], 1'b1);
    drive_reading(3, 16'h6180);
    read_status();
    check_bit("step_held", st[gauge_pkg::ST_STEP], 1'b1);
  endtask

  task automatic scen_detect();
    @(posedge clk);
    detect_pin <= 1'b1;
    repeat (8) @(posedge clk);
    read_status();
    check_bit("absent", st[gauge_pkg::ST_BST], 1'b1);
    check_bit("removed", st[gauge_pkg::ST_REM], 1'b1);
    host_u.clear_flags(16'h0001 << gauge_pkg::ST_REM);
    detect_pin <= 1'b0;
    repeat (8) @(posedge clk);
    read_status();
    check_bit("present", st[gauge_pkg::ST_BST], 1'b0);
    check_bit("inserted", st[gauge_pkg::ST_INS], 1'b1);
    check_bit("removed_clr", st[gauge_pkg::ST_REM], 1'b0);
  endtask

  task automatic scen_results();
    logic [7:0]  adrs [6];
    logic [15:0] vals [6];
    logic [15:0] d;
    int          n;
    adrs = '{gauge_pkg::ADDR_REM_CAP, gauge_pkg::ADDR_SOC, gauge_pkg::ADDR_FULL_CAP,
             gauge_pkg::ADDR_TTE, gauge_pkg::ADDR_CYCLES, gauge_pkg::ADDR_TTF};
    // Full-scale and mixed words show that no field is scaled or clipped on the way out
    vals = '{16'hFFFF, 16'h6400, 16'h1234, 16'hFFFF, 16'hFFFF, 16'h0001};
    @(posedge clk);
    results <= {vals[0], vals[1], vals[2], vals[3], vals[4], vals[5]};
    results_valid <= 1'b1;
    @(posedge clk);
    results_valid <= 1'b0;
    host_u.read_reg(gauge_pkg::ADDR_REM_CAP, d);
    check("early_result", d, 16'h0000);
    cfg[5] = 1'b1;
    write_cfg();
    n = 0;
    while (results_ready !== 1'b1 && n < VALID_N + 10) begin
      @(posedge clk);
      n++;
    end
    check_bit("valid_delay", n inside {[VALID_N - 1 : VALID_N + 2]}, 1'b1);
    for (int i = 0; i < 6; i++) begin
      host_u.read_reg(adrs[i], d);
      check("result_word", d, vals[i]);
    end
    cfg[5] = 1'b0;
    write_cfg();
    repeat (2) @(posedge clk);
    check_bit("ready_drop", results_ready, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk           = 1'b0;
    srst          = 1'b1;
    meas          = '0;
    meas_valid    = 1'b0;
    results       = '0;
    results_valid = 1'b0;
    detect_pin    = 1'b0;
    cfg           = 6'h00;
    num_errors    = 0;
    comparisons   = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    scen_reset();
    scen_limits();
    scen_alert();
    scen_step();
    scen_detect();
    scen_results();
    wrap_up();
  end

  // About 270 cycles are needed; the margin covers a slow valid timer
  initial begin
    #(100 * 5000);
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
